// ==== rtl/dbg_test_port.sv ====
/*
  Debug and test front end: scan mode latch, debug serial unit
  registers over APB, half-rate trace port.
  Assumes one 50 MHz clock; test pins arrive asynchronously.
*/
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module dbg_test_port #(
  parameter logic [31:0] CHIP_ID = dbg_test_pkg::CHIP_ID_DEFAULT,
  parameter int FIFO_DEPTH = dbg_test_pkg::FIFO_BYTES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic test_strap_a_i,
  input wire logic test_strap_b_i,
  input wire logic scan_mode_select_i,
  input wire logic test_logic_reset_n_i,
  input wire logic debug_channel_tx_flag_i,
  input wire logic debug_channel_rx_flag_i,
  input wire logic app_valid_i,
  input wire logic [2:0] core_status_i,
  input wire logic core_packet_valid_i,
  input wire logic [7:0] core_packet_i,
  input wire logic dbg_serial_rx_i,
  output logic dbg_serial_tx_o,
  output logic ice_select_o,
  output logic bscan_select_o,
  output logic [5:0] scan_chain_en_o,
  output logic test_mode_fault_o,
  output logic debug_irq_o,
  output logic dma_rx_req_o,
  output logic dma_tx_req_o,
  output logic trace_clock_out_o,
  output logic trace_branch_sync_o,
  output logic [2:0] pipeline_status_o,
  output logic [15:0] trace_packet_lines_o,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] pins_s;
  dbg_sync2 #(.WIDTH(7)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i({test_strap_a_i, test_strap_b_i, scan_mode_select_i,
          test_logic_reset_n_i, debug_channel_tx_flag_i,
          debug_channel_rx_flag_i, dbg_serial_rx_i}),
    .q_o(pins_s)
  );
  wire strap_a_s = pins_s[6];
  wire strap_b_s = pins_s[5];
  wire sel_s = pins_s[4];
  wire trst_n_s = pins_s[3];
  wire debug_channel_tx_flag_s = pins_s[2];
  wire debug_channel_rx_flag_s = pins_s[1];
  wire rx_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // Scan mode latch
  dbg_test_pkg::scan_mode_e mode;
  // Select is taken one edge after the synced test reset rises
  logic trst_seen;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      trst_seen <= 1'b0;
    else
      trst_seen <= trst_n_s;
  end
  wire both_reset = !reset_n_i || !trst_n_s || !trst_seen;
  always_ff @(posedge clk_sys_i)
  begin
    if (both_reset)
      mode <= sel_s ? dbg_test_pkg::MODE_BSCAN : dbg_test_pkg::MODE_ICE;
  end
  assign ice_select_o = (mode == dbg_test_pkg::MODE_ICE);
  assign bscan_select_o = (mode == dbg_test_pkg::MODE_BSCAN);
  // Emulation chains held off by their own test reset
  assign scan_chain_en_o = (ice_select_o && trst_n_s) ? 6'h3F : 6'h00;
  assign test_mode_fault_o = strap_a_s || strap_b_s;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl;
  logic [7:0] tx_hold;
  logic tx_pend;
  logic [7:0] rx_hold;
  logic rx_full;
  logic [1:0] comm_sticky;
  logic boot_en;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit_ctrl = (paddr == dbg_test_pkg::OFS_CTRL);
  wire hit_stat = (paddr == dbg_test_pkg::OFS_STATUS);
  wire hit_tx = (paddr == dbg_test_pkg::OFS_TXDATA);
  wire hit_rx = (paddr == dbg_test_pkg::OFS_RXDATA);
  wire hit_id = (paddr == dbg_test_pkg::OFS_CHIPID);
  wire hit_tr = (paddr == dbg_test_pkg::OFS_TRACE);
  wire hit_sc = (paddr == dbg_test_pkg::OFS_SCAN);
  wire mapped = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_id | hit_tr
                | hit_sc;
  wire debug_serial_unit_en = ctrl[dbg_test_pkg::CTRL_DEBUG_SERIAL_UNIT_EN] || boot_en;
  wire trace_en = ctrl[dbg_test_pkg::CTRL_TRACE_EN];
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  wire tx_take = tx_pend && !tx_busy && debug_serial_unit_en;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (wr && (hit_id || hit_stat
                   || hit_rx || hit_tr || hit_sc)));
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      ctrl <= dbg_test_pkg::CTRL_RESET;
      boot_en <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
        ctrl <= pwdata;
      boot_en <= !app_valid_i && !ctrl[dbg_test_pkg::CTRL_BOOT_DONE];
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      tx_hold <= 8'h00;
      tx_pend <= 1'b0;
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
      comm_sticky <= 2'b00;
    end
    else
    begin
      if (wr && hit_tx && !tx_pend)
      begin
        tx_hold <= pwdata[7:0];
        tx_pend <= 1'b1;
      end
      else if (tx_take)
        tx_pend <= 1'b0;
      if (rx_valid)
      begin
        rx_hold <= rx_data;
        rx_full <= 1'b1;
      end
      else if (rd && hit_rx)
        rx_full <= 1'b0;
      // Event wins over read-clear
      comm_sticky <= {debug_channel_tx_flag_s, debug_channel_rx_flag_s}
                     | ((rd && hit_stat) ? 2'b00 : comm_sticky);
    end
  end
  assign debug_irq_o = |comm_sticky;
  assign dma_rx_req_o = rx_full && debug_serial_unit_en;
  assign dma_tx_req_o = !tx_pend && debug_serial_unit_en;
  wire [31:0] stat_word = {24'h000000, boot_en, trst_n_s, bscan_select_o,
                           comm_sticky, tx_pend, tx_busy, rx_full};
  wire [31:0] trace_word = {8'(FIFO_DEPTH), 4'(dbg_test_pkg::TRACE_COUNTERS),
                            4'(dbg_test_pkg::MAP_INPUTS),
                            4'(dbg_test_pkg::DATA_CMPS),
                            4'(dbg_test_pkg::ADDR_CMP_PAIRS),
                            4'(dbg_test_pkg::SEQUENCERS), 4'h0};
  wire [31:0] rdata_mux =
    hit_ctrl ? ctrl :
    hit_stat ? stat_word :
    hit_rx ? {24'h000000, rx_hold} :
    hit_id ? CHIP_ID :
    hit_tr ? trace_word :
    hit_sc ? {26'h0, scan_chain_en_o} : 32'h00000000;
  assign prdata = (psel && !pwrite) ? rdata_mux : 32'h00000000;

  dbg_uart u_uart (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .enable_i(debug_serial_unit_en),
    .rx_i(rx_s),
    .tx_o(dbg_serial_tx_o),
    .tx_valid_i(tx_take),
    .tx_data_i(tx_hold),
    .tx_busy_o(tx_busy),
    .rx_valid_o(rx_valid),
    .rx_data_o(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Half-rate trace port
  logic div;
  logic [7:0] pkt_lo;
  logic pkt_lo_v;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i || !trace_en)
    begin
      div <= 1'b0;
      trace_clock_out_o <= 1'b0;
      pipeline_status_o <= 3'h0;
      trace_packet_lines_o <= 16'h0000;
      trace_branch_sync_o <= 1'b0;
      pkt_lo <= 8'h00;
      pkt_lo_v <= 1'b0;
    end
    else
    begin
      div <= !div;
      if (!div)
        trace_clock_out_o <= !trace_clock_out_o;
      if (core_packet_valid_i && !div)
      begin
        pkt_lo <= core_packet_i;
        pkt_lo_v <= 1'b1;
      end
      if (div)
      begin
        // Outputs change midway between trace clock edges
        pipeline_status_o <= core_status_i;
        trace_branch_sync_o <= (core_status_i[1:0] == 2'(dbg_test_pkg::PST_BRANCH));
        if (core_status_i[1:0] == 2'(dbg_test_pkg::PST_FAIL))
          trace_packet_lines_o <= 16'h0000;
        else
          trace_packet_lines_o <= {core_packet_valid_i ? core_packet_i
                                   : 8'h00, pkt_lo_v ? pkt_lo : 8'h00};
        pkt_lo_v <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_half_rate_clk: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i || !trace_en)
    $changed(trace_clock_out_o) |=> $stable(trace_clock_out_o) or !trace_en)
    else $error("trace clock faster than half rate");
  a_status_edge: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i || !trace_en)
    $changed(pipeline_status_o) |-> $stable(trace_clock_out_o))
    else $error("status changed on trace clock edge");
  a_fail_no_pkt: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (trace_en && div && core_status_i[1:0] == 2'b10) |=>
    trace_packet_lines_o == 16'h0000)
    else $error("packet on failed condition");
  a_sync_branch: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    trace_branch_sync_o |-> pipeline_status_o[1:0] == 2'b11)
    else $error("sync without branch status");
  a_mode_hold: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (!both_reset && $past(!both_reset)) |-> $stable(mode))
    else $error("mode changed outside reset");
  a_ice_route: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    ice_select_o |-> !bscan_select_o)
    else $error("both scan routes selected");
  a_chipid_ro: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (rd && hit_id) |-> prdata == CHIP_ID)
    else $error("chip id read wrong");
  a_irq_sticky: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    debug_channel_rx_flag_s |=> debug_irq_o)
    else $error("debug channel event lost");
  a_pkt_between: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i || !trace_en)
    $changed(trace_packet_lines_o) |-> $stable(trace_clock_out_o))
    else $error("packet changed on trace clock edge");
  a_chain_gate: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    !trst_n_s |-> scan_chain_en_o == 6'h00)
    else $error("scan chains live during test reset");
  a_boot_unit: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (!app_valid_i && !ctrl[dbg_test_pkg::CTRL_BOOT_DONE]) |=> debug_serial_unit_en)
    else $error("serial unit off without application");
endmodule : dbg_test_port

// ==== rtl/dbg_test_pkg.sv ====
/*
  Constants shared by the debug and test front end.
  Assumes a single 50 MHz system clock and an APB register port.
*/
package dbg_test_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD = 115_200;
  localparam int BAUD_DIV = CLK_HZ / BAUD;
  localparam int FIFO_BYTES = 18;
  localparam int SCAN_CHAINS = 6;
  localparam int ADDR_CMP_PAIRS = 4;
  localparam int DATA_CMPS = 2;
  localparam int MAP_INPUTS = 8;
  localparam int TRACE_COUNTERS = 2;
  localparam int SEQUENCERS = 1;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_TXDATA = 12'h008;
  localparam logic [11:0] OFS_RXDATA = 12'h00C;
  localparam logic [11:0] OFS_CHIPID = 12'h010;
  localparam logic [11:0] OFS_TRACE = 12'h014;
  localparam logic [11:0] OFS_SCAN = 12'h018;
  // Control fields
  localparam int CTRL_DEBUG_SERIAL_UNIT_EN = 0;
  localparam int CTRL_TRACE_EN = 1;
  localparam int CTRL_BOOT_DONE = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Arbitrary neutral identification value
  localparam logic [31:0] CHIP_ID_DEFAULT = 32'h0A5A_0001;
  typedef enum logic [1:0] {
    MODE_ICE = 2'b00,
    MODE_BSCAN = 2'b01
  } scan_mode_e;
  typedef enum logic [1:0] {
    PST_IDLE = 2'b00,
    PST_EXEC = 2'b01,
    PST_BRANCH = 2'b11,
    PST_FAIL = 2'b10
  } pst_e;
endpackage : dbg_test_pkg

// ==== rtl/dbg_sync2.sv ====
/*
  Two-flop synchroniser for signals from outside the clock domain.
  Assumes reset_n_i is synchronous to clk_sys_i.
*/
`timescale 1ns/100ps
module dbg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : dbg_sync2

// ==== rtl/dbg_uart.sv ====
/*
  Two-wire debug serial unit: 8N1 transmitter and receiver.
  Assumes rx_i already synchronised; baud tick is a one-cycle enable.
*/
`timescale 1ns/100ps
module dbg_uart #(
  parameter int DIV = dbg_test_pkg::BAUD_DIV
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic rx_i,
  output logic tx_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_busy_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  logic [15:0] tcnt;
  logic [15:0] rcnt;
  logic [3:0] tbit;
  logic [3:0] rbit;
  logic [9:0] tsh;
  logic [7:0] rsh;
  logic rbusy;
  wire tick_t = (tcnt == 16'(DIV - 1));
  wire tick_r = (rcnt == 16'(DIV - 1));
  wire rx_start = enable_i && !rbusy && !rx_i;
  assign tx_busy_o = (tbit != 4'h0);
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      tcnt <= 16'h0000;
      tbit <= 4'h0;
      tsh <= 10'h3FF;
      tx_o <= 1'b1;
    end
    else if (!tx_busy_o)
    begin
      tx_o <= 1'b1;
      tcnt <= 16'h0000;
      if (tx_valid_i && enable_i)
      begin
        tsh <= {1'b1, tx_data_i, 1'b0};
        tbit <= 4'hA;
      end
    end
    else
    begin
      tx_o <= tsh[0];
      tcnt <= tick_t ? 16'h0000 : tcnt + 16'h0001;
      if (tick_t)
      begin
        tsh <= {1'b1, tsh[9:1]};
        tbit <= tbit - 4'h1;
      end
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      rcnt <= 16'h0000;
      rbit <= 4'h0;
      rsh <= 8'h00;
      rbusy <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (rx_start)
      begin
        rbusy <= 1'b1;
        rcnt <= 16'(DIV / 2);
        rbit <= 4'h0;
      end
      else if (rbusy)
      begin
        rcnt <= tick_r ? 16'h0000 : rcnt + 16'h0001;
        if (tick_r)
        begin
          rbit <= rbit + 4'h1;
          if (rbit >= 4'h1 && rbit <= 4'h8)
            rsh <= {rx_i, rsh[7:1]};
          if (rbit == 4'h9)
          begin
            rbusy <= 1'b0;
            rx_valid_o <= rx_i;
            rx_data_o <= rsh;
          end
        end
      end
    end
  end
endmodule : dbg_uart

// ==== dv/dbg_serial_peer.sv ====
/*
  Far-side model of the debug serial link: host terminal, 8N1.
  Assumes the same clock as the block and a line that idles high.
*/
`timescale 1ns/100ps
module dbg_serial_peer #(
  parameter int DIV = dbg_test_pkg::BAUD_DIV
) (
  input wire logic clk_sys_i,
  input wire logic tx_line_i,
  output logic rx_line_o
);
  ////////////////////////////////////////////////////////////////
  // Line idles high between frames
  initial rx_line_o = 1'b1;

  // Start bit, eight data bits LSB first, stop bit
  task send_byte(input logic [7:0] b);
    integer i;
    @(posedge clk_sys_i);
    rx_line_o <= 1'b0;
    repeat (DIV) @(posedge clk_sys_i);
    for (i = 0; i < 8; i++)
    begin
      rx_line_o <= b[i];
      repeat (DIV) @(posedge clk_sys_i);
    end
    rx_line_o <= 1'b1;
    repeat (DIV) @(posedge clk_sys_i);
  endtask : send_byte

  // Waits for a start bit, then samples mid-bit
  task get_byte(output logic [7:0] b, output logic ok);
    integer n;
    integer i;
    n = 0;
    while (tx_line_i !== 1'b0 && n < 20000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    ok = (n < 20000);
    repeat (DIV / 2) @(posedge clk_sys_i);
    for (i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge clk_sys_i);
      b[i] = tx_line_i;
    end
    repeat (DIV) @(posedge clk_sys_i);
    ok = ok && (tx_line_i === 1'b1);
  endtask : get_byte
endmodule : dbg_serial_peer

// ==== dv/debug_trace_test_port_bench.sv ====
/*
  Self-checking bench for the debug and test front end.
  Assumes APB with zero wait states and a host serial peer model.
*/
`timescale 1ns/100ps
module debug_trace_test_port_bench;
  logic clk_sys_i, reset_n_i, strap_a, strap_b, sel, trst_n;
  logic ch_tx, ch_rx, app_valid, pkt_valid;
  logic [2:0] status;
  logic [7:0] pkt;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_line, tx_line, emulation_logic, bscan, fault, irq, trace_clock_out, trace_branch_sync, err;
  logic [5:0] chains;
  logic dma_rx, dma_tx;
  logic [2:0] pst;
  logic [15:0] lines;
  int err_count, compares;

  dbg_test_port i_dbg_test_port (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .test_strap_a_i(strap_a),
    .test_strap_b_i(strap_b), .scan_mode_select_i(sel),
    .test_logic_reset_n_i(trst_n), .debug_channel_tx_flag_i(ch_tx),
    .debug_channel_rx_flag_i(ch_rx), .app_valid_i(app_valid),
    .core_status_i(status), .core_packet_valid_i(pkt_valid),
    .core_packet_i(pkt), .dbg_serial_rx_i(rx_line),
    .dbg_serial_tx_o(tx_line), .ice_select_o(emulation_logic),
    .bscan_select_o(bscan), .scan_chain_en_o(chains),
    .test_mode_fault_o(fault), .debug_irq_o(irq), .dma_rx_req_o(dma_rx),
    .dma_tx_req_o(dma_tx), .trace_clock_out_o(trace_clock_out),
    .trace_branch_sync_o(trace_branch_sync), .pipeline_status_o(pst),
    .trace_packet_lines_o(lines), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  dbg_serial_peer i_dbg_serial_peer (.clk_sys_i(clk_sys_i),
    .tx_line_i(tx_line), .rx_line_o(rx_line));

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wait_cyc

  task print_verdict;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////
  task t_ident;
    apb(1'b0, dbg_test_pkg::OFS_CHIPID, 32'h0);
    check(rd, dbg_test_pkg::CHIP_ID_DEFAULT);
    check({31'h0, err}, 32'h0);
    apb(1'b1, dbg_test_pkg::OFS_CHIPID, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, dbg_test_pkg::OFS_CHIPID, 32'h0);
    check(rd, dbg_test_pkg::CHIP_ID_DEFAULT);
    apb(1'b0, 12'h040, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, dbg_test_pkg::OFS_TRACE, 32'h0);
    check(rd, 32'h1228_2410);
    apb(1'b0, dbg_test_pkg::OFS_SCAN, 32'h0);
    check(rd, 32'h0000_003F);
  endtask : t_ident

  task t_straps;
    wait_cyc(1);
    check({31'h0, fault}, 32'h0);
    strap_a <= 1'b1;
    wait_cyc(4);
    check({31'h0, fault}, 32'h1);
    strap_a <= 1'b0;
    strap_b <= 1'b1;
    wait_cyc(4);
    check({31'h0, fault}, 32'h1);
    strap_b <= 1'b0;
    wait_cyc(4);
    check({31'h0, fault}, 32'h0);
  endtask : t_straps

  task t_irq;
    check({31'h0, irq}, 32'h0);
    ch_rx <= 1'b1;
    wait_cyc(5);
    check({31'h0, irq}, 32'h1);
    ch_rx <= 1'b0;
    wait_cyc(5);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, dbg_test_pkg::OFS_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    ch_tx <= 1'b1;
    wait_cyc(5);
    check({31'h0, irq}, 32'h1);
    ch_tx <= 1'b0;
    wait_cyc(5);
    apb(1'b0, dbg_test_pkg::OFS_STATUS, 32'h0);
    check({31'h0, rd[4]}, 32'h1);
  endtask : t_irq

  task t_boot;
    apb(1'b0, dbg_test_pkg::OFS_STATUS, 32'h0);
    check({31'h0, rd[7]}, 32'h1);
    app_valid <= 1'b1;
    wait_cyc(2);
    apb(1'b0, dbg_test_pkg::OFS_STATUS, 32'h0);
    check({31'h0, rd[7]}, 32'h0);
  endtask : t_boot

  task t_uart;
    logic [7:0] b;
    logic ok;
    apb(1'b1, dbg_test_pkg::OFS_CTRL, 32'h0000_0003);
    fork
      i_dbg_serial_peer.get_byte(b, ok);
      apb(1'b1, dbg_test_pkg::OFS_TXDATA, 32'h0000_00A5);
    join
    check({24'h0, b}, 32'h0000_00A5);
    check({31'h0, ok}, 32'h1);
    i_dbg_serial_peer.send_byte(8'h3C);
    wait_cyc(4);
    apb(1'b0, dbg_test_pkg::OFS_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    check({31'h0, dma_rx}, 32'h1);
    apb(1'b0, dbg_test_pkg::OFS_RXDATA, 32'h0);
    check({24'h0, rd[7:0]}, 32'h0000_003C);
    wait_cyc(1);
    check({31'h0, dma_rx}, 32'h0);
    check({31'h0, dma_tx}, 32'h1);
  endtask : t_uart

  task t_trace;
    int toggles;
    int doubles;
    int syncs;
    logic prev;
    logic was_change;
    toggles = 0;
    doubles = 0;
    syncs = 0;
    was_change = 1'b0;
    status <= 3'b011;
    pkt_valid <= 1'b1;
    pkt <= 8'h5A;
    wait_cyc(1);
    prev = trace_clock_out;
    repeat (40)
    begin
      wait_cyc(1);
      if (trace_branch_sync === 1'b1)
        syncs++;
      if (trace_clock_out !== prev)
      begin
        toggles++;
        if (was_change)
          doubles++;
      end
      was_change = (trace_clock_out !== prev);
      prev = trace_clock_out;
    end
    check(toggles, 20);
    check(doubles, 0);
    check({31'h0, syncs > 0}, 32'h1);
    check({29'h0, pst}, 32'h3);
    check({24'h0, lines[7:0]}, 32'h5A);
    status <= 3'b010;
    pkt_valid <= 1'b0;
    wait_cyc(8);
    check({29'h0, pst}, 32'h2);
    check({16'h0, lines}, 32'h0);
  endtask : t_trace

  task t_mode;
    check({30'h0, emulation_logic, bscan}, 32'h2);
    check({26'h0, chains}, 32'h3F);
    trst_n <= 1'b0;
    wait_cyc(4);
    check({26'h0, chains}, 32'h0);
    trst_n <= 1'b1;
    wait_cyc(4);
    sel <= 1'b1;
    wait_cyc(6);
    check({30'h0, emulation_logic, bscan}, 32'h2);
    reset_n_i <= 1'b0;
    trst_n <= 1'b0;
    wait_cyc(4);
    reset_n_i <= 1'b1;
    trst_n <= 1'b1;
    wait_cyc(5);
    check({30'h0, emulation_logic, bscan}, 32'h1);
    check({26'h0, chains}, 32'h0);
    check({31'h0, tx_line}, 32'h1);
  endtask : t_mode

  ////////////////////////////////////////////////////////////////
  initial
  begin
    err_count = 0;
    compares = 0;
    reset_n_i = 1'b0;
    trst_n = 1'b0;
    strap_a = 1'b0;
    strap_b = 1'b0;
    sel = 1'b0;
    ch_tx = 1'b0;
    ch_rx = 1'b0;
    app_valid = 1'b0;
    status = 3'b000;
    pkt_valid = 1'b0;
    pkt = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    trst_n <= 1'b1;
    wait_cyc(2);
    t_ident;
    t_straps;
    t_irq;
    t_boot;
    t_uart;
    t_trace;
    t_mode;
    print_verdict;
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    err_count++;
    print_verdict;
  end
endmodule : debug_trace_test_port_bench
